// File: core/sfcs_pkg.sv
// Constants, register map and carrier types of the serial flow-control and status block.
// Assumes a single 250 MHz clock shared with the CPU port and the character framer.
package sfcs_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned TICK_TIME_MS = 10;
   localparam int unsigned CLK_FREQ_MHZ = 250;
   localparam int unsigned TICK_CYCLES  = TICK_TIME_MS * 1000 * 1000 / 1000 * CLK_FREQ_MHZ;

   // ----------------------------------------------------------------
   // Buffer-memory word port and register indexes
   // ----------------------------------------------------------------
   localparam int AW = 12;
   localparam int DW = 16;
   localparam logic [AW-1:0] OFF_RX_TERM_LOW   = 12'h00a;
   localparam logic [AW-1:0] OFF_RX_TERM_HIGH  = 12'h00b;
   localparam logic [AW-1:0] OFF_SUSPEND_WAIT  = 12'h00c;
   localparam logic [AW-1:0] OFF_TX_REMAINING  = 12'h00d;
   localparam logic [AW-1:0] OFF_RX_WORDS      = 12'h00e;
   localparam logic [AW-1:0] OFF_TX_SUM        = 12'h00f;
   localparam logic [AW-1:0] OFF_RX_SUM        = 12'h010;
   localparam logic [AW-1:0] OFF_CTS_DELAY     = 12'h014;
   localparam logic [AW-1:0] OFF_POST_DELAY    = 12'h015;
   localparam logic [AW-1:0] OFF_LINK_STATUS   = 12'h01c;
   localparam logic [DW-1:0] DELAY_MASK        = 16'h7fff;
   localparam logic [DW-1:0] REG_RESET         = 16'h0000;

   // ----------------------------------------------------------------
   // Status word bit positions
   // ----------------------------------------------------------------
   localparam int ST_TX_DONE = 0;
   localparam int ST_RX_DONE = 1;
   localparam int ST_RX_TO   = 2;
   localparam int ST_ERR     = 3;
   localparam int ST_SUSP    = 4;
   localparam int ST_SENDING = 6;
   localparam int ST_RECEIVE = 7;
   localparam int ST_RTS     = 8;
   localparam int ST_DTR     = 9;
   localparam int ST_DSR     = 12;
   localparam int ST_DCD     = 13;
   localparam int ST_CTS     = 14;
   localparam int ST_RI      = 15;

   // ----------------------------------------------------------------
   // Modes, counts, error codes
   // ----------------------------------------------------------------
   localparam logic [1:0] MODE_NONE = 2'h0;
   localparam logic [1:0] MODE_STD  = 2'h1;
   localparam logic [1:0] MODE_LINK = 2'h3;
   localparam logic [9:0] MAX_BYTES_16 = 10'h200;
   localparam logic [9:0] MAX_BYTES_8  = 10'h100;
   localparam logic [9:0] SPARE_16     = 10'h01e;
   localparam logic [9:0] SPARE_8      = 10'h00f;
   localparam logic [7:0] ERR_NONE     = 8'h00;
   localparam logic [7:0] ERR_RX_LINE  = 8'h01;
   localparam logic [7:0] ERR_RX_SUM   = 8'h02;
   localparam logic [7:0] ERR_TX       = 8'h03;

   typedef struct packed {
      logic err_reset;
      logic rx_reset;
      logic send;
      logic enable;
   } sfcs_cmd_t;

   typedef struct packed {
      logic [1:0] line_mode;
      logic       buf_8bit;
      logic [9:0] max_rx_bytes;
      logic [14:0] rx_timeout;
      logic [9:0] tx_byte_count;
   } sfcs_cfg_t;

   typedef struct packed {
      logic ri;
      logic cts;
      logic dcd;
      logic dsr;
   } sfcs_pins_t;

   typedef struct packed {
      logic       valid;
      logic       first_hdr;
      logic       is_data;
      logic [7:0] data;
   } sfcs_byte_t;

   typedef enum logic [2:0] {
      TX_IDLE,
      TX_WAIT_CTS,
      TX_DELAY,
      TX_SEND,
      TX_POST
   } sfcs_tx_state_t;

endpackage

// File: core/sfcs_core.sv
// Flow control, delay timing, checksum and status logic of a buffered serial interface.
// Assumes the framer, command word and config sit on the same clock; modem pins are async.
// Function
// - Receive terminator up to four bytes in two words; leading zeros ignored, zero disables.
// - Suspension wait register holds 0..32767 ticks of 10 ms, resets to zero.
// - Interlink mode: reaching max receive count drops the receive-ready line.
// - After dropping receive-ready, wait suspension time, then set suspended status.
// - While suspended no incoming byte is accepted.
// - Remaining-send count is programmed count minus bytes sent; max 512 or 256.
// - Received-word count covers main and 15-word overflow buffer, up to 271.
// - Send checksum: byte sum minus first header, low byte as two ASCII digits.
// - Receive checksum stored; mismatch with appended sum raises a sum error.
// - Send starts after CTS plus delay, or after command plus delay without lines.
// - After last byte wait post-send time, then drop receive-ready in standard mode, set send done.
// - Send-complete bit sets when count is sent, clears on next send command.
// - Receive-complete sets at terminator match, receive timeout or max count (not in interlink mode).
// - No new reception while receive-complete is set; reset command clears it.
// - Receive timeout sets bit 2 with bit 1; reset command clears bit 2.
// - Any send or receive error sets bit 3 and writes the error code.
// - Bit 6 high from send command until send-complete sets.
// - Bit 7 high from first received byte until receive-complete sets.
// - Bits 8,9,12..15 show RTS, DTR, DSR, DCD, CTS, RI live; bits 5, 10 and 11 zero.
// - Interlink reset command clears suspended and count, reasserts receive-ready.
// - Nonzero receive timeout flags when next byte misses the tick window.
`timescale 1ns/1ps
module sfcs_core #(
   parameter int unsigned TICK_CYCLES = sfcs_pkg::TICK_CYCLES
) (
   input  wire logic                  clock,
   input  wire logic                  reset_n,
   input  wire logic [sfcs_pkg::AW-1:0] bm_addr,
   input  wire logic [sfcs_pkg::DW-1:0] bm_wdata,
   input  wire logic                  bm_write,
   input  wire logic                  bm_read,
   output logic      [sfcs_pkg::DW-1:0] bm_rdata,
   input  wire sfcs_pkg::sfcs_cmd_t   cmd,
   input  wire sfcs_pkg::sfcs_cfg_t   cfg,
   input  wire sfcs_pkg::sfcs_pins_t  pins,
   input  wire sfcs_pkg::sfcs_byte_t  rx_byte,
   input  wire logic                  rx_line_err,
   input  wire logic                  rx_sum_valid,
   input  wire logic [7:0]            rx_sum_value,
   input  wire sfcs_pkg::sfcs_byte_t  tx_byte,
   input  wire logic                  tx_frame_end,
   input  wire logic                  tx_err,
   output logic                       receive_ready_line,
   output logic                       terminal_ready_line,
   output logic                       tx_go,
   output logic [15:0]                tx_sum_ascii,
   output logic [7:0]                 error_code
);
   import sfcs_pkg::*;

   localparam int TW = $clog2(TICK_CYCLES + 1);
   // ASCII "00": the send sum digits before any byte is summed
   localparam logic [15:0] SUM_ASCII_RESET = 16'h3030;

   function automatic logic [7:0] hex_ascii(input logic [3:0] nib);
      hex_ascii = (nib < 4'ha) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers, command edges, tick
   // ----------------------------------------------------------------
   sfcs_pins_t pins_meta, pins_sync;
   sfcs_cmd_t  cmd_q;
   logic [TW-1:0] tick_cnt;
   logic       tick;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pins_meta <= '0;
         pins_sync <= '0;
         cmd_q     <= '0;
         tick_cnt  <= '0;
         tick      <= 1'b0;
      end else begin
         pins_meta <= pins;
         pins_sync <= pins_meta;
         cmd_q     <= cmd;
         tick      <= (tick_cnt == TW'(TICK_CYCLES - 1));
         tick_cnt  <= (tick_cnt == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
      end
   end

   wire en_rise    = cmd.enable & ~cmd_q.enable;
   wire send_rise  = cmd.send & ~cmd_q.send & cmd.enable;
   wire rx_rst     = cmd.rx_reset & ~cmd_q.rx_reset;
   wire err_rst    = (cmd.err_reset & ~cmd_q.err_reset) | en_rise;
   wire link_mode  = (cfg.line_mode == MODE_LINK);
   wire std_mode   = (cfg.line_mode == MODE_STD);

   // ----------------------------------------------------------------
   // Registers written over the word port
   // ----------------------------------------------------------------
   logic [DW-1:0] term_low, term_high, suspend_wait, cts_delay, post_delay;
   logic [31:0]   term_act;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         term_low     <= REG_RESET;
         term_high    <= REG_RESET;
         suspend_wait <= REG_RESET;
         cts_delay    <= REG_RESET;
         post_delay   <= REG_RESET;
         term_act     <= '0;
      end else begin
         if (bm_write && bm_addr == OFF_RX_TERM_LOW)  term_low  <= bm_wdata;
         if (bm_write && bm_addr == OFF_RX_TERM_HIGH) term_high <= bm_wdata;
         if (bm_write && bm_addr == OFF_SUSPEND_WAIT) suspend_wait <= bm_wdata & DELAY_MASK;
         if (bm_write && bm_addr == OFF_CTS_DELAY)    cts_delay  <= bm_wdata & DELAY_MASK;
         if (bm_write && bm_addr == OFF_POST_DELAY)   post_delay <= bm_wdata & DELAY_MASK;
         if (en_rise || rx_rst) term_act <= {term_high, term_low};
      end
   end

   // ----------------------------------------------------------------
   // Terminator mask: bytes from the highest nonzero one downward
   // ----------------------------------------------------------------
   logic [4:0]  keep;
   logic [31:0] term_mask;
   assign keep[4] = 1'b0;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_term
         assign keep[gi] = (|term_act[8*gi +: 8]) | keep[gi+1];
         assign term_mask[8*gi +: 8] = {8{keep[gi]}};
      end
   endgenerate
   wire term_used = keep[0];

   // ----------------------------------------------------------------
   // Receive path
   // ----------------------------------------------------------------
   logic [9:0]  rx_count;
   logic [31:0] rx_shift;
   logic [15:0] rx_sum;
   logic [14:0] idle_cnt, susp_cnt;
   logic        rx_done, rx_to, receiving, hold, suspended;

   wire [9:0]  eff_max   = (cfg.max_rx_bytes == 10'h000) ?
                           (cfg.buf_8bit ? MAX_BYTES_8 : MAX_BYTES_16) : cfg.max_rx_bytes;
   wire [9:0]  spare     = cfg.buf_8bit ? SPARE_8 : SPARE_16;
   wire [9:0]  rx_limit  = link_mode ? eff_max + spare : eff_max;
   wire        accept    = rx_byte.valid & cmd.enable & ~rx_done & ~suspended
                           & (rx_count < rx_limit);
   wire        data_acc  = accept & rx_byte.is_data;
   wire [9:0]  cnt_next  = rx_count + 10'h001;
   wire [31:0] shift_nx  = {rx_shift[23:0], rx_byte.data};
   wire        term_hit  = accept & term_used &
                           ((shift_nx & term_mask) == (term_act & term_mask));
   wire        max_hit   = data_acc & ~link_mode & (cnt_next == eff_max);
   wire        hold_hit  = data_acc & link_mode & ~hold & (cnt_next >= eff_max);
   wire        to_hit    = receiving & ~rx_done & (cfg.rx_timeout != 15'h0000) &
                           tick & (idle_cnt <= 15'h0001);
   wire        done_set  = term_hit | max_hit | to_hit;
   wire        cont_cmd  = rx_rst & link_mode;
   wire        sum_bad   = rx_sum_valid & (rx_sum_value != rx_sum[7:0]);
   wire [9:0]  rx_words  = cfg.buf_8bit ? rx_count : 10'((rx_count + 10'h001) >> 1);

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rx_count  <= '0;
         rx_shift  <= '0;
         rx_sum    <= '0;
         idle_cnt  <= '0;
         susp_cnt  <= '0;
         rx_done   <= 1'b0;
         rx_to     <= 1'b0;
         receiving <= 1'b0;
         hold      <= 1'b0;
         suspended <= 1'b0;
      end else begin
         if (rx_rst || en_rise) begin
            rx_count <= '0;
            rx_shift <= '0;
            rx_sum   <= '0;
         end else if (accept) begin
            if (rx_byte.is_data) rx_count <= cnt_next;
            rx_shift <= shift_nx;
            if (!rx_byte.first_hdr) rx_sum <= rx_sum + {8'h00, rx_byte.data};
         end
         if (accept) idle_cnt <= cfg.rx_timeout;
         else if (tick && idle_cnt != 15'h0000) idle_cnt <= idle_cnt - 1'b1;
         rx_done   <= done_set | (rx_done & ~rx_rst);
         rx_to     <= to_hit | (rx_to & ~rx_rst);
         receiving <= ~done_set & (accept | (receiving & ~rx_rst));
         if (hold_hit) begin
            hold     <= 1'b1;
            susp_cnt <= suspend_wait[14:0];
         end else if (cont_cmd || !link_mode) begin
            hold <= 1'b0;
         end else if (hold && !suspended && tick && susp_cnt != 15'h0000) begin
            susp_cnt <= susp_cnt - 1'b1;
         end
         // Continue must beat the level-held set, or suspension never ends
         suspended <= ~cont_cmd & link_mode &
                      ((hold & ~hold_hit & (susp_cnt == 15'h0000)) | suspended);
      end
   end

   // ----------------------------------------------------------------
   // Send sequencer
   // ----------------------------------------------------------------
   sfcs_tx_state_t tx_state;
   logic [14:0] dcnt;
   logic [9:0]  tx_remaining;
   logic [15:0] tx_sum;
   logic        tx_done, sending, rts_std, rts_link, err_flag;

   wire [15:0] tx_sum_nx = tx_sum + {8'h00, tx_byte.data};

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tx_state     <= TX_IDLE;
         dcnt         <= '0;
         tx_remaining <= '0;
         tx_sum       <= '0;
         tx_sum_ascii <= SUM_ASCII_RESET;
         tx_done      <= 1'b0;
         sending      <= 1'b0;
         tx_go        <= 1'b0;
         rts_std      <= 1'b0;
      end else begin
         if (send_rise) begin
            tx_done      <= 1'b0;
            sending      <= 1'b1;
            tx_remaining <= cfg.tx_byte_count;
            tx_sum       <= '0;
            dcnt         <= cts_delay[14:0];
            rts_std      <= std_mode;
            tx_state     <= std_mode ? TX_WAIT_CTS : TX_DELAY;
         end else begin
            case (tx_state)
               TX_WAIT_CTS: begin
                  if (pins_sync.cts) tx_state <= TX_DELAY;
               end
               TX_DELAY: begin
                  if (dcnt == 15'h0000) begin
                     tx_go    <= 1'b1;
                     tx_state <= TX_SEND;
                  end else if (tick) begin
                     dcnt <= dcnt - 1'b1;
                  end
               end
               TX_SEND: begin
                  if (tx_byte.valid && !tx_byte.first_hdr) begin
                     tx_sum       <= tx_sum_nx;
                     tx_sum_ascii <= {hex_ascii(tx_sum_nx[7:4]), hex_ascii(tx_sum_nx[3:0])};
                  end
                  if (tx_byte.valid && tx_byte.is_data && tx_remaining != 10'h000)
                     tx_remaining <= tx_remaining - 1'b1;
                  if (tx_frame_end) begin
                     tx_go    <= 1'b0;
                     dcnt     <= post_delay[14:0];
                     tx_state <= TX_POST;
                  end
               end
               TX_POST: begin
                  if (dcnt == 15'h0000) begin
                     tx_done  <= 1'b1;
                     sending  <= 1'b0;
                     rts_std  <= 1'b0;
                     tx_state <= TX_IDLE;
                  end else if (tick) begin
                     dcnt <= dcnt - 1'b1;
                  end
               end
               default: tx_state <= TX_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Lines, errors, status and word read-back
   // ----------------------------------------------------------------
   wire err_set = sum_bad | rx_line_err | tx_err;
   wire [7:0] err_nx = sum_bad ? ERR_RX_SUM : (rx_line_err ? ERR_RX_LINE : ERR_TX);
   wire [DW-1:0] status = {pins_sync.ri, pins_sync.cts, pins_sync.dcd, pins_sync.dsr,
                           2'b00, terminal_ready_line, receive_ready_line,
                           receiving, sending, 1'b0, suspended,
                           err_flag, rx_to, rx_done, tx_done};
   wire [DW-1:0] rd_mux =
      (bm_addr == OFF_RX_TERM_LOW)  ? term_low :
      (bm_addr == OFF_RX_TERM_HIGH) ? term_high :
      (bm_addr == OFF_SUSPEND_WAIT) ? suspend_wait :
      (bm_addr == OFF_TX_REMAINING) ? {6'h00, tx_remaining} :
      (bm_addr == OFF_RX_WORDS)     ? {6'h00, rx_words} :
      (bm_addr == OFF_TX_SUM)       ? tx_sum :
      (bm_addr == OFF_RX_SUM)       ? rx_sum :
      (bm_addr == OFF_CTS_DELAY)    ? cts_delay :
      (bm_addr == OFF_POST_DELAY)   ? post_delay :
      (bm_addr == OFF_LINK_STATUS)  ? status : REG_RESET;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         err_flag            <= 1'b0;
         error_code          <= ERR_NONE;
         rts_link            <= 1'b0;
         receive_ready_line  <= 1'b0;
         terminal_ready_line <= 1'b0;
         bm_rdata            <= REG_RESET;
      end else begin
         err_flag <= err_set | (err_flag & ~err_rst);
         if (err_set) error_code <= err_nx;
         else if (err_rst) error_code <= ERR_NONE;
         if (hold_hit || !cmd.enable || !link_mode) rts_link <= 1'b0;
         else if (en_rise || cont_cmd || (!hold && !rts_link)) rts_link <= 1'b1;
         receive_ready_line  <= link_mode ? (rts_link & ~hold_hit) : (rts_std & cmd.enable);
         terminal_ready_line <= cmd.enable;
         if (bm_read) bm_rdata <= rd_mux;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_susp_range;
      @(posedge clock) disable iff (!reset_n) suspend_wait <= 16'h7fff;
   endproperty
   a_susp_range: assert property (p_susp_range) else $error("suspend wait out of range");

   property p_hold_rts;
      @(posedge clock) disable iff (!reset_n)
         link_mode && hold && !cont_cmd |=> !receive_ready_line;
   endproperty
   a_hold_rts: assert property (p_hold_rts) else $error("receive-ready high while held");

   property p_susp_zero;
      @(posedge clock) disable iff (!reset_n)
         hold_hit && suspend_wait == 16'h0000 ##1 !cont_cmd |=> suspended;
   endproperty
   a_susp_zero: assert property (p_susp_zero) else $error("suspend not set after zero wait");

   property p_no_accept;
      @(posedge clock) disable iff (!reset_n)
         (suspended || rx_done) && !rx_rst && !en_rise |=> $stable(rx_count);
   endproperty
   a_no_accept: assert property (p_no_accept) else $error("byte taken while blocked");

   property p_words;
      @(posedge clock) disable iff (!reset_n) rx_words <= 10'd271 && tx_remaining <= 10'd512;
   endproperty
   a_words: assert property (p_words) else $error("count out of range");

   property p_tx_clear;
      @(posedge clock) disable iff (!reset_n) send_rise |=> !tx_done && sending;
   endproperty
   a_tx_clear: assert property (p_tx_clear) else $error("send command did not clear done");

   property p_done_ends_send;
      @(posedge clock) disable iff (!reset_n) $rose(tx_done) |-> $fell(sending);
   endproperty
   a_done_ends_send: assert property (p_done_ends_send) else $error("sending not ended");

   property p_timeout;
      @(posedge clock) disable iff (!reset_n) to_hit |=> rx_to && rx_done && !receiving;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout flags not set");

   property p_error;
      @(posedge clock) disable iff (!reset_n)
         sum_bad |=> err_flag && error_code == ERR_RX_SUM;
   endproperty
   a_error: assert property (p_error) else $error("sum error not reported");

   property p_zero_delay;
      @(posedge clock) disable iff (!reset_n)
         tx_state == TX_DELAY && dcnt == 15'h0000 && !send_rise |=> tx_go;
   endproperty
   a_zero_delay: assert property (p_zero_delay) else $error("send not started");

   property p_status_read;
      @(posedge clock) disable iff (!reset_n)
         bm_read && bm_addr == OFF_LINK_STATUS |=>
            bm_rdata[ST_CTS] == $past(pins_sync.cts) && bm_rdata[ST_DTR] == $past(cmd.enable, 2);
   endproperty
   a_status_read: assert property (p_status_read) else $error("status word wrong");

   property p_tick;
      @(posedge clock) disable iff (!reset_n) tick |=> !tick;
   endproperty
   a_tick: assert property (p_tick) else $error("tick longer than one cycle");

   c_term: cover property (@(posedge clock) disable iff (!reset_n) term_hit);
   c_susp: cover property (@(posedge clock) disable iff (!reset_n) $rose(suspended));
   c_send: cover property (@(posedge clock) disable iff (!reset_n) $rose(tx_done));
   c_to:   cover property (@(posedge clock) disable iff (!reset_n) to_hit);

endmodule

// File: bench/sfcs_far_end.sv
// Far-end serial equipment: modem pins and received-byte strobes.
// Assumes it is called from the bench just after a rising clock edge.
`timescale 1ns/1ps
module sfcs_far_end (
   input  wire logic            clock,
   input  wire logic            receive_ready_line,
   input  wire logic            flow_on,
   output sfcs_pkg::sfcs_pins_t pins,
   output sfcs_pkg::sfcs_byte_t rx_byte
);
   import sfcs_pkg::*;
   initial pins = '0;
   initial rx_byte = '0;
   task automatic set_pins(input logic [3:0] p);
      pins = p;
   endtask
   // Sends one byte whatever the receive-ready line says
   task automatic push(input logic [7:0] d);
      @(posedge clock) #1 rx_byte = {3'b101, d};
      @(posedge clock) #1 rx_byte = {3'b000, ~d};
   endtask
   // Drops the byte if the receiver asks to pause in interlink mode
   task automatic put(input logic [7:0] d);
      if (!flow_on || receive_ready_line) push(d);
   endtask
endmodule

// File: bench/sfcs_core_bench.sv
// Self-checking bench of the flow-control and status block.
// Assumes a far-end model for pins and bytes; the tick is cut to 8 clocks.
`timescale 1ns/1ps
module sfcs_core_bench;
   import sfcs_pkg::*;
   logic       clock = 1'b0, reset_n = 1'b0, bm_write = 1'b0, bm_read = 1'b0, tx_frame_end = 1'b0;
   logic       [AW-1:0] bm_addr = '0;
   logic       [DW-1:0] bm_wdata = '0, bm_rdata, tx_sum_ascii;
   sfcs_cmd_t  cmd = '0;
   sfcs_cfg_t  cfg = {MODE_NONE, 1'b1, 10'h008, 15'h0000, 10'h002};
   sfcs_pins_t pins;
   sfcs_byte_t rx_byte, tx_byte = '0;
   logic       receive_ready_line, tx_go;
   logic       rx_line_err = 1'b0, rx_sum_valid = 1'b0, tx_err = 1'b0, terminal_ready_line;
   logic       [7:0] rx_sum_value = 8'h45, error_code;
   int         num_errors = 0, n_compared = 0;
   always #2 clock = ~clock;
   sfcs_core #(.TICK_CYCLES(8)) dut (.clock(clock), .reset_n(reset_n), .bm_addr(bm_addr),
      .bm_wdata(bm_wdata), .bm_write(bm_write), .bm_read(bm_read), .bm_rdata(bm_rdata),
      .cmd(cmd), .cfg(cfg), .pins(pins), .rx_byte(rx_byte), .rx_line_err(rx_line_err),
      .rx_sum_valid(rx_sum_valid), .rx_sum_value(rx_sum_value), .tx_byte(tx_byte),
      .tx_frame_end(tx_frame_end), .tx_err(tx_err), .receive_ready_line(receive_ready_line),
      .terminal_ready_line(terminal_ready_line), .tx_go(tx_go), .tx_sum_ascii(tx_sum_ascii),
      .error_code(error_code));
   sfcs_far_end far (.clock(clock), .receive_ready_line(receive_ready_line),
      .flow_on(cfg.line_mode == MODE_LINK), .pins(pins), .rx_byte(rx_byte));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", n, e, g);
         num_errors++;
      end
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clock) #1 {bm_addr, bm_wdata, bm_write} = {a, d, 1'b1};
      @(posedge clock) #1 bm_write = 1'b0;
   endtask
   task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
      @(posedge clock) #1 {bm_addr, bm_read} = {a, 1'b1};
      @(posedge clock) #1 bm_read = 1'b0;
      chk($sformatf("word %h", a), e, bm_rdata);
   endtask
   task automatic pulse(input int b);
      @(posedge clock) #1 cmd[b] = 1'b1;
      @(posedge clock) #1 cmd[b] = 1'b0;
   endtask
   task automatic put_tx(input logic [7:0] d);
      @(posedge clock) #1 tx_byte = {3'b101, d};
      @(posedge clock) #1 tx_byte = '0;
   endtask
   task automatic strobe(input logic [2:0] s, input logic [7:0] e);
      @(posedge clock) #1 {rx_line_err, rx_sum_valid, tx_err} = s;
      @(posedge clock) #1 {rx_line_err, rx_sum_valid, tx_err} = 3'b000;
      chk("error_code", {8'h00, e}, {8'h00, error_code});
   endtask
   task automatic test_done;
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge clock);
      num_errors++;
      test_done;
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clock);
      #1 reset_n = 1'b1;
      rd(OFF_SUSPEND_WAIT, 16'h0000);
      rd(OFF_TX_SUM, 16'h0000);
      rd(OFF_RX_SUM, 16'h0000);
      rd(12'h001, 16'h0000);
      wr(OFF_SUSPEND_WAIT, 16'hffff);
      rd(OFF_SUSPEND_WAIT, 16'h7fff);
      wr(OFF_RX_TERM_LOW, 16'h0003);
      far.set_pins(4'hd);
      cmd.enable = 1'b1;
      repeat (3) @(posedge clock);
      rd(OFF_LINK_STATUS, 16'hd200);
      chk("terminal_ready_line", 16'h0001, {15'h0000, terminal_ready_line});
      far.put(8'h41);
      far.put(8'h03);
      repeat (2) @(posedge clock);
      rd(OFF_LINK_STATUS, 16'hd202);
      rd(OFF_RX_SUM, 16'h0044);
      strobe(3'b010, ERR_RX_SUM);
      strobe(3'b100, ERR_RX_LINE);
      strobe(3'b001, ERR_TX);
      rd(OFF_LINK_STATUS, 16'hd20a);
      pulse(3);
      chk("error_code", {8'h00, ERR_NONE}, {8'h00, error_code});
      wr(OFF_RX_TERM_LOW, 16'h0000);
      cfg.max_rx_bytes = 10'h003;
      pulse(2);
      repeat (4) far.put(8'h55);
      rd(OFF_RX_WORDS, 16'h0003);
      rd(OFF_LINK_STATUS, 16'hd202);
      cfg.rx_timeout = 15'h0002;
      pulse(2);
      far.put(8'h60);
      repeat (40) @(posedge clock);
      rd(OFF_LINK_STATUS, 16'hd206);
      pulse(2);
      pulse(1);
      rd(OFF_LINK_STATUS, 16'hd240);
      rd(OFF_TX_REMAINING, 16'h0002);
      for (int i = 0; i < 50 && tx_go !== 1'b1; i++) @(posedge clock);
      chk("tx_go", 16'h0001, {15'h0000, tx_go});
      put_tx(8'h31);
      put_tx(8'h32);
      rd(OFF_TX_REMAINING, 16'h0000);
      @(posedge clock) #1 tx_frame_end = 1'b1;
      @(posedge clock) #1 tx_frame_end = 1'b0;
      repeat (3) @(posedge clock);
      rd(OFF_LINK_STATUS, 16'hd201);
      rd(OFF_TX_SUM, 16'h0063);
      chk("tx_sum_ascii", 16'h3633, tx_sum_ascii);
      // Interlink: hold at the maximum, suspend, refuse, continue
      cfg = {MODE_LINK, 1'b1, 10'h002, 15'h0000, 10'h001};
      wr(OFF_SUSPEND_WAIT, 16'h0002);
      repeat (3) far.put(8'h20);
      rd(OFF_LINK_STATUS, 16'hd281);
      repeat (20) @(posedge clock);
      rd(OFF_LINK_STATUS, 16'hd291);
      rd(OFF_RX_WORDS, 16'h0002);
      far.push(8'h21);
      rd(OFF_RX_WORDS, 16'h0002);
      pulse(2);
      rd(OFF_LINK_STATUS, 16'hd301);
      rd(OFF_RX_WORDS, 16'h0000);
      // Standard mode: wait for CTS, then delays before and after sending
      cfg = {MODE_STD, 1'b1, 10'h002, 15'h0000, 10'h001};
      wr(OFF_CTS_DELAY, 16'h0001);
      wr(OFF_POST_DELAY, 16'h0001);
      far.set_pins(4'h9);
      pulse(1);
      repeat (20) @(posedge clock);
      chk("tx_go", 16'h0000, {15'h0000, tx_go});
      rd(OFF_LINK_STATUS, 16'h9340);
      far.set_pins(4'hd);
      for (int i = 0; i < 50 && tx_go !== 1'b1; i++) @(posedge clock);
      chk("tx_go", 16'h0001, {15'h0000, tx_go});
      put_tx(8'h10);
      @(posedge clock) #1 tx_frame_end = 1'b1;
      @(posedge clock) #1 tx_frame_end = 1'b0;
      rd(OFF_LINK_STATUS, 16'hd340);
      repeat (20) @(posedge clock);
      rd(OFF_LINK_STATUS, 16'hd201);
      chk("tx_sum_ascii", 16'h3130, tx_sum_ascii);
      test_done;
   end
endmodule
